// ### core/cap_pkg.sv
package cap_pkg;

  // ***********************************************************
  // SFR byte addresses
  // ***********************************************************
  localparam logic [15:0] CAP_OFS_BANK_BASE = 16'hfe10;
  localparam logic [15:0] CAP_OFS_STACK_TOP = 16'hfe12;
  localparam logic [15:0] CAP_OFS_PAGE0 = 16'hfe00;
  localparam logic [15:0] CAP_OFS_PAGE1 = 16'hfe02;
  localparam logic [15:0] CAP_OFS_PAGE2 = 16'hfe04;
  localparam logic [15:0] CAP_OFS_PAGE3 = 16'hfe06;

  // ***********************************************************
  // Reset values
  // ***********************************************************
  localparam logic [15:0] CAP_RST_BANK_BASE = 16'hfc00;
  localparam logic [15:0] CAP_RST_STACK_TOP = 16'hfc00;
  localparam logic [15:0] CAP_RST_PAGE0 = 16'h0000;
  localparam logic [15:0] CAP_RST_PAGE1 = 16'h0001;
  localparam logic [15:0] CAP_RST_PAGE2 = 16'h0002;
  localparam logic [15:0] CAP_RST_PAGE3 = 16'h0003;

  // ***********************************************************
  // Field layout
  // ***********************************************************
  localparam int CAP_PAGE_W = 10;
  localparam int CAP_OFF_W = 14;
  localparam int CAP_NUM_DPP = 4;
  localparam logic [3:0] CAP_PTR_TOP_ONES = 4'hf;
  localparam logic [2:0] CAP_BANK_LOW_FIELD = 3'h0;
  localparam logic [1:0] CAP_BANK_FORCE = 2'h3;
  localparam logic [3:0] CAP_REG8_GPR_HI = 4'hf;
  localparam logic [15:0] CAP_STACK_STEP = 16'h0002;

  typedef logic [CAP_PAGE_W-1:0] cap_page_t;

  // ***********************************************************
  // Modes and access kinds
  // ***********************************************************
  typedef enum logic [1:0] {
    CAP_NONSEG = 2'b00,
    CAP_SEG_2 = 2'b01,
    CAP_SEG_4 = 2'b10,
    CAP_SEG_8 = 2'b11
  } cap_seg_mode_e;

  typedef enum logic [1:0] {
    CAP_XL_PAGED = 2'b00,
    CAP_XL_EXT = 2'b01,
    CAP_XL_EVENT = 2'b10,
    CAP_XL_RSVD = 2'b11
  } cap_xl_kind_e;

endpackage : cap_pkg

// ### core/cap_addr_xlate.sv
`timescale 1ns/100ps
module cap_addr_xlate
  import cap_pkg::*;
(
  input wire logic [15:0] laddr,
  input wire cap_xl_kind_e kind,
  input wire cap_seg_mode_e seg_mode,
  input wire logic ext_access,
  input wire cap_page_t ext_page,
  input wire cap_page_t page0,
  input wire cap_page_t page1,
  input wire cap_page_t page2,
  input wire cap_page_t page3,
  output logic [23:0] phys,
  output logic [7:0] seg_pins
);

  cap_page_t sel_page;

  // ***********************************************************
  // Page selection by top address bits
  // ***********************************************************
  always_comb begin
    unique case (laddr[15:14])
      2'b00: sel_page = page0;
      2'b01: sel_page = page1;
      2'b10: sel_page = page2;
      default: sel_page = page3;
    endcase
  end

  // ***********************************************************
  // Physical address and segment pins
  // ***********************************************************
  always_comb begin
    phys = 24'h000000;
    seg_pins = 8'h00;
    unique case (kind)
      CAP_XL_EXT: phys = {ext_page, laddr[CAP_OFF_W-1:0]};
      CAP_XL_EVENT: phys = {8'h00, laddr};
      CAP_XL_RSVD: phys = {8'h00, laddr};
      default: begin
        if (seg_mode == CAP_NONSEG) begin
          phys = {8'h00, sel_page[1:0], laddr[CAP_OFF_W-1:0]};
        end else begin
          phys = {sel_page, laddr[CAP_OFF_W-1:0]};
        end
      end
    endcase
    if (ext_access) begin
      unique case (seg_mode)
        CAP_SEG_2: seg_pins = {6'h00, phys[17:16]};
        CAP_SEG_4: seg_pins = {4'h0, phys[19:16]};
        CAP_SEG_8: seg_pins = phys[23:16];
        default: seg_pins = 8'h00;
      endcase
    end
  end

endmodule : cap_addr_xlate

// ### core/cap_ptr_regs.sv
// Contract
// - Page pointers use low 10 bits as page number; upper 6 reserved.
// - Paged address is page number joined to low 14 logical bits.
// - Translate paged accesses, but not extended overrides or event xfers.
// - Reset page pointers to pages 0..3 so addresses map identically.
// - Non-segmented mode uses only two low page bits.
// - Segmented mode drives selected page bits onto segment pins only when ext_access is set; otherwise pins stay 0.
// - New page pointer takes effect one instruction late.
// - All pointers writable as special function registers.
// - Bank base addresses first of up to 16 general registers.
// - New bank base takes effect one instruction late.
// - Context switch pushes old bank base, loads new, one cycle.
// - Bank base write with bits 11..9 zero forces bits 11..10 high.
// - Short 4-bit address added to bank base, doubled for words.
// - Pointer registers read as words; 8-bit addresses use same sum.
// - 8-bit register address F0h..FFh treated as short bank address.
// - Bit access uses word address plus separate 4-bit bit position.
// - Stack pointer pre-decrements on push, post-increments on pop.
// - Stack pointer bit 0 zero, bits 15..12 one.
`timescale 1ns/100ps
module cap_ptr_regs
  import cap_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic instr_end,
  input wire logic sfr_wr_en,
  input wire logic sfr_rd_en,
  input wire logic [15:0] sfr_addr,
  input wire logic [15:0] sfr_wdata,
  output logic [15:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic xlate_req,
  input wire logic [15:0] xlate_laddr,
  input wire cap_xl_kind_e xlate_kind,
  input wire cap_seg_mode_e seg_mode,
  input wire logic ext_access,
  input wire cap_page_t ext_page,
  output logic xlate_ack,
  output logic [23:0] phys_addr,
  output logic [7:0] seg_addr_pins,
  input wire logic gpr_req,
  input wire logic gpr_word,
  input wire logic gpr_is_reg8,
  input wire logic [7:0] gpr_short_addr,
  input wire logic [3:0] gpr_bit_pos,
  output logic gpr_ack,
  output logic gpr_hit,
  output logic [15:0] gpr_addr,
  output logic [3:0] gpr_bit,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic switch_context_op,
  input wire logic [15:0] switch_context_new,
  output logic stack_ack,
  output logic [15:0] top_of_stack,
  output logic [15:0] stack_wr_data,
  output logic stack_wr_en
);

  // ***********************************************************
  // Helper functions
  // ***********************************************************
  function automatic logic [15:0] fix_ptr(input logic [15:0] v);
    fix_ptr = {CAP_PTR_TOP_ONES, v[11:1], 1'b0};
  endfunction : fix_ptr

  function automatic logic [15:0] fix_bank(input logic [15:0] v);
    logic [15:0] r;
    r = fix_ptr(v);
    if (v[11:9] == CAP_BANK_LOW_FIELD) begin
      r[11:10] = CAP_BANK_FORCE;
    end
    fix_bank = r;
  endfunction : fix_bank

  function automatic logic [15:0] bank_addr(input logic [15:0] base,
      input logic [3:0] n, input logic word);
    if (word) begin
      bank_addr = base + {11'h000, n, 1'b0};
    end else begin
      bank_addr = base + {12'h000, n};
    end
  endfunction : bank_addr

  // ***********************************************************
  // Registers
  // ***********************************************************
  logic [15:0] dpp_reg [CAP_NUM_DPP];
  logic [15:0] dpp_next [CAP_NUM_DPP];
  cap_page_t dpp_stage_reg [CAP_NUM_DPP];
  cap_page_t dpp_use_reg [CAP_NUM_DPP];
  logic [15:0] bank_reg;
  logic [15:0] bank_next;
  logic [15:0] bank_stage_reg;
  logic [15:0] bank_use_reg;
  logic [15:0] sp_reg;
  logic [15:0] sp_next;
  logic [3:0] dpp_wr;
  logic bank_wr;
  logic sp_wr;
  logic [23:0] xl_phys;
  logic [7:0] xl_seg;
  logic [3:0] short_n;
  logic short_ok;

  always_comb begin
    dpp_wr[0] = sfr_wr_en && (sfr_addr == CAP_OFS_PAGE0);
    dpp_wr[1] = sfr_wr_en && (sfr_addr == CAP_OFS_PAGE1);
    dpp_wr[2] = sfr_wr_en && (sfr_addr == CAP_OFS_PAGE2);
    dpp_wr[3] = sfr_wr_en && (sfr_addr == CAP_OFS_PAGE3);
    bank_wr = sfr_wr_en && (sfr_addr == CAP_OFS_BANK_BASE);
    sp_wr = sfr_wr_en && (sfr_addr == CAP_OFS_STACK_TOP);
  end

  // ***********************************************************
  // Page pointers
  // ***********************************************************
  always_comb begin
    for (int i = 0; i < CAP_NUM_DPP; i++) begin
      dpp_next[i] = dpp_reg[i];
      if (dpp_wr[i]) begin
        dpp_next[i] = {6'h00, sfr_wdata[CAP_PAGE_W-1:0]};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dpp_reg[0] <= CAP_RST_PAGE0;
      dpp_reg[1] <= CAP_RST_PAGE1;
      dpp_reg[2] <= CAP_RST_PAGE2;
      dpp_reg[3] <= CAP_RST_PAGE3;
    end else begin
      for (int i = 0; i < CAP_NUM_DPP; i++) begin
        dpp_reg[i] <= dpp_next[i];
      end
    end
  end

  // Two-stage copy so the next instruction still sees the old page
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dpp_stage_reg[0] <= CAP_RST_PAGE0[CAP_PAGE_W-1:0];
      dpp_stage_reg[1] <= CAP_RST_PAGE1[CAP_PAGE_W-1:0];
      dpp_stage_reg[2] <= CAP_RST_PAGE2[CAP_PAGE_W-1:0];
      dpp_stage_reg[3] <= CAP_RST_PAGE3[CAP_PAGE_W-1:0];
      dpp_use_reg[0] <= CAP_RST_PAGE0[CAP_PAGE_W-1:0];
      dpp_use_reg[1] <= CAP_RST_PAGE1[CAP_PAGE_W-1:0];
      dpp_use_reg[2] <= CAP_RST_PAGE2[CAP_PAGE_W-1:0];
      dpp_use_reg[3] <= CAP_RST_PAGE3[CAP_PAGE_W-1:0];
    end else if (instr_end) begin
      for (int i = 0; i < CAP_NUM_DPP; i++) begin
        dpp_stage_reg[i] <= dpp_next[i][CAP_PAGE_W-1:0];
        dpp_use_reg[i] <= dpp_stage_reg[i];
      end
    end
  end

  // ***********************************************************
  // Bank base and stack pointer
  // ***********************************************************
  always_comb begin
    bank_next = bank_reg;
    sp_next = sp_reg;
    if (switch_context_op) begin
      bank_next = fix_bank(switch_context_new);
      sp_next = fix_ptr(sp_reg - CAP_STACK_STEP);
    end else begin
      if (bank_wr) begin
        bank_next = fix_bank(sfr_wdata);
      end
      if (sp_wr) begin
        sp_next = fix_ptr(sfr_wdata);
      end else if (stack_push) begin
        sp_next = fix_ptr(sp_reg - CAP_STACK_STEP);
      end else if (stack_pop) begin
        sp_next = fix_ptr(sp_reg + CAP_STACK_STEP);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bank_reg <= CAP_RST_BANK_BASE;
      bank_stage_reg <= CAP_RST_BANK_BASE;
      bank_use_reg <= CAP_RST_BANK_BASE;
    end else begin
      bank_reg <= bank_next;
      if (instr_end) begin
        bank_stage_reg <= bank_next;
        bank_use_reg <= bank_stage_reg;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sp_reg <= CAP_RST_STACK_TOP;
    end else begin
      sp_reg <= sp_next;
    end
  end

  // Stack access address: new top on push, old top on pop
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stack_ack <= 1'b0;
      stack_wr_en <= 1'b0;
      top_of_stack <= CAP_RST_STACK_TOP;
      stack_wr_data <= 16'h0000;
    end else begin
      stack_ack <= switch_context_op || stack_push || stack_pop;
      stack_wr_en <= switch_context_op || stack_push;
      if (switch_context_op || stack_push) begin
        top_of_stack <= fix_ptr(sp_reg - CAP_STACK_STEP);
      end else if (stack_pop) begin
        top_of_stack <= sp_reg;
      end
      if (switch_context_op) begin
        stack_wr_data <= bank_reg;
      end
    end
  end

  // ***********************************************************
  // SFR read port
  // ***********************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sfr_rdata <= 16'h0000;
      sfr_hit <= 1'b0;
    end else if (sfr_rd_en) begin
      sfr_hit <= 1'b1;
      unique case (sfr_addr)
        CAP_OFS_PAGE0: sfr_rdata <= dpp_reg[0];
        CAP_OFS_PAGE1: sfr_rdata <= dpp_reg[1];
        CAP_OFS_PAGE2: sfr_rdata <= dpp_reg[2];
        CAP_OFS_PAGE3: sfr_rdata <= dpp_reg[3];
        CAP_OFS_BANK_BASE: sfr_rdata <= bank_reg;
        CAP_OFS_STACK_TOP: sfr_rdata <= sp_reg;
        default: begin
          sfr_rdata <= 16'h0000;
          sfr_hit <= 1'b0;
        end
      endcase
    end else begin
      sfr_hit <= 1'b0;
    end
  end

  // ***********************************************************
  // Data address translation
  // ***********************************************************
  cap_addr_xlate u_xlate (
    .laddr(xlate_laddr),
    .kind(xlate_kind),
    .seg_mode(seg_mode),
    .ext_access(ext_access),
    .ext_page(ext_page),
    .page0(dpp_use_reg[0]),
    .page1(dpp_use_reg[1]),
    .page2(dpp_use_reg[2]),
    .page3(dpp_use_reg[3]),
    .phys(xl_phys),
    .seg_pins(xl_seg)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      xlate_ack <= 1'b0;
      phys_addr <= 24'h000000;
      seg_addr_pins <= 8'h00;
    end else begin
      xlate_ack <= xlate_req;
      if (xlate_req) begin
        phys_addr <= xl_phys;
        seg_addr_pins <= xl_seg;
      end
    end
  end

  // ***********************************************************
  // Short register address resolution
  // ***********************************************************
  always_comb begin
    short_n = gpr_short_addr[3:0];
    short_ok = !gpr_is_reg8 ||
        (gpr_short_addr[7:4] == CAP_REG8_GPR_HI);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gpr_ack <= 1'b0;
      gpr_hit <= 1'b0;
      gpr_addr <= 16'h0000;
      gpr_bit <= 4'h0;
    end else begin
      gpr_ack <= gpr_req;
      if (gpr_req) begin
        gpr_hit <= short_ok;
        gpr_addr <= bank_addr(bank_use_reg, short_n, gpr_word);
        gpr_bit <= gpr_bit_pos;
      end
    end
  end

  // ***********************************************************
  // Checks
  // ***********************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_page0_wr_at_end;
    dpp_wr[0] && instr_end;
  endsequence

  sequence s_next_instr_end;
    instr_end;
  endsequence

  a_sp_tied_bits: assert property (
    sp_reg[15:12] == 4'hf && !sp_reg[0])
    else $error("stack pointer tied bits wrong");

  a_sp_push_step: assert property (
    stack_push && !sp_wr && !switch_context_op && sp_reg != 16'hf000 |=>
    sp_reg == $past(sp_reg) - 16'h0002 && top_of_stack == sp_reg)
    else $error("push did not pre-decrement");

  a_sp_pop_step: assert property (
    stack_pop && !stack_push && !sp_wr && !switch_context_op &&
    sp_reg != 16'hfffe |=>
    sp_reg == $past(sp_reg) + 16'h0002 && top_of_stack == $past(sp_reg))
    else $error("pop did not post-increment");

  a_bank_force: assert property (
    bank_wr && !switch_context_op && sfr_wdata[11:9] == 3'h0 |=>
    bank_reg[11:10] == 2'h3 && bank_reg[9:1] == $past(sfr_wdata[9:1]))
    else $error("bank base force not applied");

  a_ctx_switch: assert property (
    switch_context_op |=> stack_wr_en && stack_ack &&
    stack_wr_data == $past(bank_reg) &&
    bank_reg == fix_bank($past(switch_context_new)))
    else $error("context switch wrong");

  a_dpp_lag: assert property (
    s_page0_wr_at_end ##1 s_next_instr_end |=>
    dpp_use_reg[0] == $past(sfr_wdata[9:0], 2))
    else $error("page pointer lag wrong");

  a_dpp_hold: assert property (
    instr_end |=> dpp_use_reg[1] == $past(dpp_stage_reg[1]))
    else $error("page pointer used too early");

  a_bank_hold: assert property (
    instr_end |=> bank_use_reg == $past(bank_stage_reg))
    else $error("bank base used too early");

  a_xlate_paged: assert property (
    xlate_req && xlate_kind == CAP_XL_PAGED && seg_mode != CAP_NONSEG |=>
    xlate_ack && phys_addr[13:0] == $past(xlate_laddr[13:0]) &&
    phys_addr[23:14] == $past(dpp_use_reg[xlate_laddr[15:14]]))
    else $error("paged translation wrong");

  a_xlate_nonseg: assert property (
    xlate_req && xlate_kind == CAP_XL_PAGED && seg_mode == CAP_NONSEG |=>
    phys_addr[23:16] == 8'h00)
    else $error("non-segmented used high page bits");

  a_gpr_word_sum: assert property (
    gpr_req && gpr_word |=> gpr_ack &&
    gpr_addr == $past(bank_use_reg) + {11'h000, $past(short_n), 1'b0})
    else $error("word register address wrong");

  a_reg8_range: assert property (
    gpr_req && gpr_is_reg8 && gpr_short_addr[7:4] != 4'hf |=> !gpr_hit)
    else $error("8-bit address outside bank accepted");

endmodule : cap_ptr_regs

// ### test/tb.sv
`timescale 1ns/100ps
module tb;
  import cap_pkg::*;

  // ***********************************************************
  // Signals and design
  // ***********************************************************
  logic ref_clk, rst, instr_end, sfr_wr_en, sfr_rd_en;
  logic [15:0] sfr_addr, sfr_wdata, sfr_rdata, xlate_laddr;
  logic sfr_hit, xlate_req, ext_access, xlate_ack;
  cap_xl_kind_e xlate_kind;
  cap_seg_mode_e seg_mode;
  cap_page_t ext_page;
  logic [23:0] phys_addr;
  logic [7:0] seg_addr_pins, gpr_short_addr;
  logic gpr_req, gpr_word, gpr_is_reg8, gpr_ack, gpr_hit;
  logic [3:0] gpr_bit_pos, gpr_bit;
  logic [15:0] gpr_addr, switch_context_new, top_of_stack, stack_wr_data;
  logic stack_push, stack_pop, switch_context_op, stack_ack, stack_wr_en;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  cap_ptr_regs i_cap_ptr_regs (
    .ref_clk(ref_clk),
    .rst(rst),
    .instr_end(instr_end),
    .sfr_wr_en(sfr_wr_en),
    .sfr_rd_en(sfr_rd_en),
    .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit),
    .xlate_req(xlate_req),
    .xlate_laddr(xlate_laddr),
    .xlate_kind(xlate_kind),
    .seg_mode(seg_mode),
    .ext_access(ext_access),
    .ext_page(ext_page),
    .xlate_ack(xlate_ack),
    .phys_addr(phys_addr),
    .seg_addr_pins(seg_addr_pins),
    .gpr_req(gpr_req),
    .gpr_word(gpr_word),
    .gpr_is_reg8(gpr_is_reg8),
    .gpr_short_addr(gpr_short_addr),
    .gpr_bit_pos(gpr_bit_pos),
    .gpr_ack(gpr_ack),
    .gpr_hit(gpr_hit),
    .gpr_addr(gpr_addr),
    .gpr_bit(gpr_bit),
    .stack_push(stack_push),
    .stack_pop(stack_pop),
    .switch_context_op(switch_context_op),
    .switch_context_new(switch_context_new),
    .stack_ack(stack_ack),
    .top_of_stack(top_of_stack),
    .stack_wr_data(stack_wr_data),
    .stack_wr_en(stack_wr_en)
  );

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ***********************************************************
  // Tasks
  // ***********************************************************
  task summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    sfr_wr_en <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge ref_clk);
    sfr_wr_en <= 1'b0;
  endtask : wr

  task rd(input logic [15:0] a, input logic [15:0] exp, input logic eh);
    @(posedge ref_clk);
    sfr_rd_en <= 1'b1;
    sfr_addr <= a;
    @(posedge ref_clk);
    sfr_rd_en <= 1'b0;
    #1;
    chk(sfr_rdata, exp);
    chk(sfr_hit, eh);
  endtask : rd

  task ie();
    @(posedge ref_clk);
    instr_end <= 1'b1;
    @(posedge ref_clk);
    instr_end <= 1'b0;
  endtask : ie

  task xl(input logic [15:0] la, input cap_xl_kind_e k,
          input cap_seg_mode_e m, input logic ext,
          input logic [23:0] ep, input logic [7:0] es);
    @(posedge ref_clk);
    xlate_req <= 1'b1;
    xlate_laddr <= la;
    xlate_kind <= k;
    seg_mode <= m;
    ext_access <= ext;
    @(posedge ref_clk);
    xlate_req <= 1'b0;
    #1;
    chk(xlate_ack, 1'b1);
    chk(phys_addr, ep);
    chk(seg_addr_pins, es);
  endtask : xl

  task gp(input logic w, input logic r8, input logic [7:0] sa,
          input logic [3:0] bp, input logic eh, input logic [15:0] ea);
    @(posedge ref_clk);
    gpr_req <= 1'b1;
    gpr_word <= w;
    gpr_is_reg8 <= r8;
    gpr_short_addr <= sa;
    gpr_bit_pos <= bp;
    @(posedge ref_clk);
    gpr_req <= 1'b0;
    #1;
    chk(gpr_ack, 1'b1);
    chk(gpr_hit, eh);
    if (eh) begin
      chk(gpr_addr, ea);
      chk(gpr_bit, bp);
    end
  endtask : gp

  task st(input logic pu, input logic po, input logic sw,
          input logic [15:0] nv, input logic [15:0] et,
          input logic ewe, input logic [15:0] ewd);
    @(posedge ref_clk);
    stack_push <= pu;
    stack_pop <= po;
    switch_context_op <= sw;
    switch_context_new <= nv;
    @(posedge ref_clk);
    stack_push <= 1'b0;
    stack_pop <= 1'b0;
    switch_context_op <= 1'b0;
    #1;
    chk(stack_ack, 1'b1);
    chk(top_of_stack, et);
    chk(stack_wr_en, ewe);
    if (sw) begin
      chk(stack_wr_data, ewd);
    end
  endtask : st

  // ***********************************************************
  // Timeout and main sequence
  // ***********************************************************
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    {instr_end, sfr_wr_en, sfr_rd_en, xlate_req, ext_access} = '0;
    {gpr_req, gpr_word, gpr_is_reg8, stack_push, stack_pop} = '0;
    switch_context_op = 1'b0;
    {sfr_addr, sfr_wdata, xlate_laddr, switch_context_new} = '0;
    gpr_short_addr = 8'h00;
    gpr_bit_pos = 4'h0;
    xlate_kind = CAP_XL_PAGED;
    seg_mode = CAP_NONSEG;
    ext_page = 10'h2a5;
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(CAP_OFS_PAGE0, 16'h0000, 1'b1);
    rd(CAP_OFS_PAGE1, 16'h0001, 1'b1);
    rd(CAP_OFS_PAGE2, 16'h0002, 1'b1);
    rd(CAP_OFS_PAGE3, 16'h0003, 1'b1);
    rd(CAP_OFS_BANK_BASE, 16'hfc00, 1'b1);
    rd(CAP_OFS_STACK_TOP, 16'hfc00, 1'b1);
    rd(16'hfe08, 16'h0000, 1'b0);
    for (int q = 0; q < 4; q++) begin
      xl({q[1:0], 14'h1555}, CAP_XL_PAGED, CAP_SEG_8, 1'b1,
         {8'h00, q[1:0], 14'h1555}, 8'h00);
    end
    gp(1'b1, 1'b0, 8'h03, 4'h0, 1'b1, 16'hfc06);
    gp(1'b0, 1'b0, 8'h03, 4'h0, 1'b1, 16'hfc03);
    gp(1'b1, 1'b0, 8'h02, 4'h0, 1'b1, 16'hfc04);
    gp(1'b1, 1'b0, 8'h0f, 4'h0, 1'b1, 16'hfc1e);
    gp(1'b1, 1'b1, 8'hf5, 4'h9, 1'b1, 16'hfc0a);
    gp(1'b0, 1'b1, 8'he5, 4'h0, 1'b0, 16'h0000);
    wr(CAP_OFS_PAGE3, 16'hffff);
    rd(CAP_OFS_PAGE3, 16'h03ff, 1'b1);
    wr(CAP_OFS_BANK_BASE, 16'h0100);
    rd(CAP_OFS_BANK_BASE, 16'hfd00, 1'b1);
    wr(CAP_OFS_BANK_BASE, 16'h3601);
    rd(CAP_OFS_BANK_BASE, 16'hf600, 1'b1);
    wr(CAP_OFS_STACK_TOP, 16'h1235);
    rd(CAP_OFS_STACK_TOP, 16'hf234, 1'b1);
    wr(CAP_OFS_STACK_TOP, 16'hfc00);
    wr(CAP_OFS_PAGE2, 16'h03a5);
    ie();
    xl(16'h8abc, CAP_XL_PAGED, CAP_SEG_8, 1'b1, 24'h008abc, 8'h00);
    gp(1'b1, 1'b0, 8'h01, 4'h0, 1'b1, 16'hfc02);
    ie();
    xl(16'h8abc, CAP_XL_PAGED, CAP_SEG_8, 1'b1, 24'he94abc, 8'he9);
    gp(1'b1, 1'b0, 8'h01, 4'h0, 1'b1, 16'hf602);
    xl(16'hc000, CAP_XL_PAGED, CAP_SEG_8, 1'b1, 24'hffc000, 8'hff);
    xl(16'h8abc, CAP_XL_PAGED, CAP_SEG_2, 1'b1, 24'he94abc, 8'h01);
    xl(16'h8abc, CAP_XL_PAGED, CAP_SEG_4, 1'b1, 24'he94abc, 8'h09);
    xl(16'h8abc, CAP_XL_PAGED, CAP_SEG_8, 1'b0, 24'he94abc, 8'h00);
    xl(16'h8abc, CAP_XL_PAGED, CAP_NONSEG, 1'b1, 24'h004abc, 8'h00);
    xl(16'h8abc, CAP_XL_EXT, CAP_SEG_8, 1'b1, 24'ha94abc, 8'ha9);
    xl(16'h8abc, CAP_XL_EVENT, CAP_SEG_8, 1'b1, 24'h008abc, 8'h00);
    xl(16'h8abc, CAP_XL_RSVD, CAP_SEG_8, 1'b1, 24'h008abc, 8'h00);
    @(posedge ref_clk);
    sfr_wr_en <= 1'b1;
    sfr_addr <= CAP_OFS_PAGE0;
    sfr_wdata <= 16'h0155;
    instr_end <= 1'b1;
    @(posedge ref_clk);
    sfr_wr_en <= 1'b0;
    @(posedge ref_clk);
    instr_end <= 1'b0;
    xl(16'h0000, CAP_XL_PAGED, CAP_SEG_8, 1'b1, 24'h554000, 8'h55);
    st(1'b1, 1'b0, 1'b0, 16'h0000, 16'hfbfe, 1'b1, 16'h0000);
    st(1'b0, 1'b1, 1'b0, 16'h0000, 16'hfbfe, 1'b0, 16'h0000);
    rd(CAP_OFS_STACK_TOP, 16'hfc00, 1'b1);
    st(1'b0, 1'b0, 1'b1, 16'h0800, 16'hfbfe, 1'b1, 16'hf600);
    rd(CAP_OFS_BANK_BASE, 16'hf800, 1'b1);
    st(1'b0, 1'b0, 1'b1, 16'h0000, 16'hfbfc, 1'b1, 16'hf800);
    rd(CAP_OFS_BANK_BASE, 16'hfc00, 1'b1);
    wr(CAP_OFS_STACK_TOP, 16'h0001);
    rd(CAP_OFS_STACK_TOP, 16'hf000, 1'b1);
    st(1'b1, 1'b0, 1'b0, 16'h0000, 16'hfffe, 1'b1, 16'h0000);
    st(1'b0, 1'b1, 1'b0, 16'h0000, 16'hfffe, 1'b0, 16'h0000);
    rd(CAP_OFS_STACK_TOP, 16'hf000, 1'b1);
    summarize();
  end
endmodule : tb
